// ### logic/drv_map.svh
// Purpose: offsets, field positions, reset values and sizes of the serial control core
// Assumes: included by bare name from the package and the design modules
// Notes:   every figure of the control word layout lives here and nowhere else
`ifndef DRV_MAP_SVH
`define DRV_MAP_SVH

// serial word
`define WORD_BITS          16
`define COUNT_BITS         4
`define LAST_BIT_INDEX     4'hf

// command word: address nibble on top, data in the low bits
`define CMD_ADDR_HI        15
`define CMD_ADDR_LO        12
`define ADDR_CTRL0         4'h0
`define ADDR_CTRL1         4'h1
`define ADDR_CTRL2         4'h2
`define ADDR_CLEAR         4'h3

// control word zero fields
`define CTRL0_ACTIVE_POS   0
`define CTRL0_PUMP_EN_POS  1
`define CTRL0_PUMP_DIS_POS 2

// channels
`define CHANNELS           6
`define DIRECT_CHANNEL     1

// reset values
`define ACTIVE_RESET       1'h0
`define PUMP_EN_RESET      1'h0
`define PUMP_DIS_RESET     1'h0
`define CHAN_RESET         6'h00
`define PWM_RESET          6'h00
`define STATUS_RESET       6'h00
`define TX_RESET           16'h0000

// reply word fields
`define REPLY_ERROR_POS    15
`define REPLY_STANDBY_POS  14
`define REPLY_PUMP_POS     13
`define REPLY_STATUS_LO    6
`define REPLY_CHAN_LO      0

// synchroniser lanes
`define SYNC_LANES         10
`define LANE_CS            0
`define LANE_DIRECT        1
`define LANE_SUPPLY        2
`define LANE_TOGGLE        3
`define LANE_FAULT_LO      4

`endif

// ### logic/drv_pkg.sv
// Purpose: types shared by the serial control core
// Assumes: drv_map.svh supplies the sizes
// Notes:   operating modes are one-hot
`default_nettype none
`include "drv_map.svh"
package drv_pkg;
  typedef enum logic [2:0] {
    MODE_OFF     = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_ACTIVE  = 3'b100
  } mode_t;

  typedef logic [`WORD_BITS-1:0] word_t;
  typedef logic [`CHANNELS-1:0]  chan_t;
endpackage
`default_nettype wire

// ### logic/bit_sync.sv
// Purpose: two flip-flop synchroniser for a group of independent levels
// Assumes: each lane is a level or a toggle, never a multi-bit word
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// ### logic/serial_shifter.sv
// Purpose: link side of the serial port, clocked by the host serial clock
// Assumes: host shifts sixteen bits per frame, msb first, sampled on rising edge
// Notes:   bit counter is cleared by chip select itself since the clock stops between frames
`timescale 1ns/100ps
`default_nettype none
`include "drv_map.svh"
module serial_shifter
  import drv_pkg::*;
(
  input  wire logic  i_serial_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_chip_select_n,
  input  wire logic  i_serial_data_in,
  input  wire word_t i_tx_word,
  output logic       o_serial_data_out,
  output word_t      o_rx_word,
  output logic       o_rx_toggle
);
  logic [`COUNT_BITS-1:0] bit_count;
  logic [`WORD_BITS-2:0]  shift;
  wire  [`COUNT_BITS-1:0] out_index;
  wire                    last_bit;

  // RULE4: counter on serial clock
  always_ff @(posedge i_serial_clk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      bit_count <= '0;
    end else begin
      bit_count <= bit_count + 4'h1;
    end
  end

  // RULE16: shift only while selected
  always_ff @(posedge i_serial_clk) begin
    if (!i_chip_select_n) begin
      shift <= {shift[`WORD_BITS-3:0], i_serial_data_in};
    end
  end

  // RULE1: sixteenth bit completes the word
  assign last_bit = !i_chip_select_n && (bit_count == `LAST_BIT_INDEX);

  // reset here is asynchronous: the link clock may never run during reset
  always_ff @(posedge i_serial_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_word   <= `TX_RESET;
      o_rx_toggle <= 1'b0;
    end else if (last_bit) begin
      o_rx_word   <= {shift, i_serial_data_in};
      o_rx_toggle <= ~o_rx_toggle;
    end
  end

  // RULE3: reply bits walk msb first while selected
  assign out_index         = `LAST_BIT_INDEX - bit_count;
  assign o_serial_data_out = i_tx_word[out_index];
endmodule
`default_nettype wire

// ### logic/driver_serial_control_core.sv
// Purpose: control core of a six-channel driver behind a host-clocked serial port
// Assumes: host keeps chip select low at least three reference clocks before the first serial edge
// Notes:   analog stages appear as enables; fault inputs are filtered outside
// Operation
// RULE1: host sends sixteen-bit words, most significant bit first.
// RULE2: data output released to high impedance while chip select is high.
// RULE3: data exchanged only while chip select is held low.
// RULE4: shift register advances only on the host serial clock.
// RULE5: direct drive input switches channel two on without any command; the code does so only in active mode, entered by a control word zero write.
// RULE6: channels in pwm mode follow the direct drive input.
// RULE7: rising logic supply triggers power-on reset of all logic; the code resets only the core registers, not the link shifter or synchroniser.
// RULE8: low logic supply floats all outputs and clears status.
// RULE9: charge pump runs only with enable one and disable zero.
// RULE10: host disables the pump when channel one is low side.
// RULE11: host uses channel one high side for any high-side configuration.
// RULE12: writing active bit zero enters standby, everything switched off.
// RULE13: standby entry clears status and restores control defaults.
// RULE14: only a serial command brings the device out of standby.
// RULE15: channel two on is direct input or its command bit; the code ignores the direct input outside active mode.
// RULE16: while deselected, serial activity is ignored and registers hold.
`timescale 1ns/100ps
`default_nettype none
`include "drv_map.svh"
module driver_serial_control_core
  import drv_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_serial_clk,
  input  wire logic  i_chip_select_n,
  input  wire logic  i_serial_data_in,
  input  wire logic  i_direct_drive,
  input  wire logic  i_logic_supply_ok,
  input  wire chan_t i_channel_fault,
  output logic       o_serial_data_out,
  output logic       o_serial_data_oe_n,
  output chan_t      o_channel_on,
  output logic       o_outputs_oe_n,
  output logic       o_charge_pump_on,
  output logic       o_gate_from_logic_supply,
  output logic       o_standby
);

  // synchronised pins and the link toggle
  logic [`SYNC_LANES-1:0] sync_in;
  logic [`SYNC_LANES-1:0] sync_out;
  wire                    cs_n_s;
  wire                    direct_s;
  wire                    supply_s;
  wire                    toggle_s;
  wire  chan_t            fault_s;

  // link crossing
  word_t                  rx_word;
  logic                   rx_toggle;
  logic                   toggle_seen;
  word_t                  tx_word;
  logic                   link_data_out;

  // mode and control state
  mode_t                  mode;
  mode_t                  next_mode;
  logic                   active_bit;
  logic                   pump_enable_bit;
  logic                   pump_disable_bit;
  chan_t                  chan_cmd;
  chan_t                  pwm_mode;
  chan_t                  status;
  chan_t                  next_channel_on;

  // decode
  wire                    core_rst;
  wire                    word_strobe;
  wire  [3:0]             cmd_addr;
  wire                    write_ctrl0;
  wire                    write_ctrl1;
  wire                    write_ctrl2;
  wire                    write_clear;
  wire                    data_active;
  wire                    standby_entry;
  wire                    standby_exit;
  wire                    hold_defaults;
  wire                    is_active;
  wire                    pump_run;
  wire  chan_t            pwm_follow;
  wire  chan_t            direct_mask;
  wire  chan_t            clear_mask;
  wire  word_t            reply_word;
  wire                    standby_state;
  wire                    ctrl0_load;
  wire                    ctrl_clear;
  wire                    reply_reload;
  wire  chan_t            direct_on;

  assign sync_in = {i_channel_fault, rx_toggle, i_logic_supply_ok, i_direct_drive, i_chip_select_n};

  bit_sync #(
    .WIDTH (`SYNC_LANES)
  ) u_sync (
    .i_clk   (i_ref_clk),
    .i_rst_n (i_rst_n),
    .i_async (sync_in),
    .o_sync  (sync_out)
  );

  assign cs_n_s   = sync_out[`LANE_CS];
  assign direct_s = sync_out[`LANE_DIRECT];
  assign supply_s = sync_out[`LANE_SUPPLY];
  assign toggle_s = sync_out[`LANE_TOGGLE];
  assign fault_s  = sync_out[`LANE_FAULT_LO +: `CHANNELS];

  // RULE4: shift register on the host clock
  serial_shifter u_shifter (
    .i_serial_clk      (i_serial_clk),
    .i_rst_n           (i_rst_n),
    .i_chip_select_n   (i_chip_select_n),
    .i_serial_data_in  (i_serial_data_in),
    .i_tx_word         (tx_word),
    .o_serial_data_out (link_data_out),
    .o_rx_word         (rx_word),
    .o_rx_toggle       (rx_toggle)
  );

  // RULE7: supply rising releases the internal reset
  // RULE8: supply loss holds the core registers in reset; the link shifter and synchroniser keep running
  assign core_rst = !i_rst_n || !supply_s;

  // a completed frame shows as a change of the synchronised toggle
  assign word_strobe = toggle_s ^ toggle_seen;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      toggle_seen <= 1'b0;
    end else begin
      toggle_seen <= toggle_s;
    end
  end

  // rx_word is stable here: the next frame needs sixteen more serial edges
  assign cmd_addr    = rx_word[`CMD_ADDR_HI:`CMD_ADDR_LO];
  assign write_ctrl0 = word_strobe && (cmd_addr == `ADDR_CTRL0);
  assign write_ctrl1 = word_strobe && (cmd_addr == `ADDR_CTRL1);
  assign write_ctrl2 = word_strobe && (cmd_addr == `ADDR_CTRL2);
  assign write_clear = word_strobe && (cmd_addr == `ADDR_CLEAR);
  assign data_active = rx_word[`CTRL0_ACTIVE_POS];
  assign clear_mask  = rx_word[`CHANNELS-1:0];

  assign is_active     = (mode == MODE_ACTIVE);
  // RULE12: active bit written zero leaves active mode
  assign standby_entry = is_active && write_ctrl0 && !data_active;
  // RULE14: only a control word zero write with the active bit leaves standby
  assign standby_state = (mode == MODE_STANDBY);
  assign standby_exit  = standby_state && write_ctrl0 && data_active;
  assign hold_defaults = !is_active || standby_entry;

  // control word zero loads on the exit write and on any active write that keeps active mode
  assign ctrl0_load    = standby_exit || (is_active && write_ctrl0 && data_active);
  // RULE13: controls and status pinned to defaults outside active mode
  assign ctrl_clear    = core_rst || hold_defaults;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_OFF: begin
        next_mode = MODE_STANDBY;
      end
      MODE_STANDBY: begin
        if (standby_exit) begin
          next_mode = MODE_ACTIVE;
        end
      end
      MODE_ACTIVE: begin
        if (standby_entry) begin
          next_mode = MODE_STANDBY;
        end
      end
      default: begin
        next_mode = MODE_OFF;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      mode <= MODE_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // control word zero; in standby only the exit write is taken
  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      active_bit       <= `ACTIVE_RESET;
      pump_enable_bit  <= `PUMP_EN_RESET;
      pump_disable_bit <= `PUMP_DIS_RESET;
    end else if (ctrl0_load) begin
      active_bit       <= 1'b1;
      pump_enable_bit  <= rx_word[`CTRL0_PUMP_EN_POS];
      pump_disable_bit <= rx_word[`CTRL0_PUMP_DIS_POS];
    end else if (hold_defaults) begin
      // RULE13: control defaults restored in standby
      active_bit       <= `ACTIVE_RESET;
      pump_enable_bit  <= `PUMP_EN_RESET;
      pump_disable_bit <= `PUMP_DIS_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (ctrl_clear) begin
      chan_cmd <= `CHAN_RESET;
    end else if (write_ctrl1) begin
      chan_cmd <= rx_word[`CHANNELS-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (ctrl_clear) begin
      pwm_mode <= `PWM_RESET;
    end else if (write_ctrl2) begin
      pwm_mode <= rx_word[`CHANNELS-1:0];
    end
  end

  // RULE8: supply loss clears status
  // RULE13: standby clears status; new faults win over a clear
  always_ff @(posedge i_ref_clk) begin
    if (ctrl_clear) begin
      status <= `STATUS_RESET;
    end else if (write_clear) begin
      status <= (status & ~clear_mask) | fault_s;
    end else begin
      status <= status | fault_s;
    end
  end

  // RULE6: pwm channels follow the direct input
  assign pwm_follow = pwm_mode & {`CHANNELS{direct_s}};
  // RULE5: direct input drives channel two with no channel command, in active mode only
  // RULE15: channel two is direct input or its command bit, in active mode only
  assign direct_mask = chan_t'(1) << `DIRECT_CHANNEL;
  assign direct_on   = direct_mask & {`CHANNELS{direct_s}};

  always_comb begin
    next_channel_on = '0;
    if (is_active) begin
      next_channel_on = chan_cmd | pwm_follow | direct_on;
    end
  end

  // RULE9: pump runs with enable one and disable zero
  assign pump_run = is_active && pump_enable_bit && !pump_disable_bit;

  // RULE12: standby switches the channel outputs and the charge pump off
  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      o_channel_on             <= `CHAN_RESET;
      o_charge_pump_on         <= 1'b0;
      o_gate_from_logic_supply <= 1'b1;
      o_standby                <= 1'b1;
    end else begin
      o_channel_on             <= next_channel_on;
      o_charge_pump_on         <= pump_run;
      o_gate_from_logic_supply <= !pump_run;
      // standby flag moves on the same edge as the outputs it switches off
      o_standby                <= !is_active;
    end
  end

  // RULE8: outputs float while the supply is low
  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      o_outputs_oe_n <= 1'b1;
    end else begin
      o_outputs_oe_n <= 1'b0;
    end
  end

  assign reply_word = {
    |status,
    !is_active,
    pump_run,
    1'b0,
    status,
    o_channel_on
  };

  // synchronised chip select only: the raw pin must not reach reference-clock logic;
  // a reload up to two cycles after selection lands well before the first serial edge
  assign reply_reload = cs_n_s;

  // reply reloads while the synchronised chip select is high, so the link sees a stable word
  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      tx_word <= `TX_RESET;
    end else if (reply_reload) begin
      tx_word <= reply_word;
    end
  end

  // RULE2: data output floats when deselected or unpowered
  // RULE3: data driven only while chip select is low
  assign o_serial_data_oe_n = i_chip_select_n || o_outputs_oe_n;
  assign o_serial_data_out  = link_data_out && !o_serial_data_oe_n;

endmodule
`default_nettype wire

// ### verification/driver_serial_control_core_sva.sv
// Purpose: port checker for the serial control core
// Assumes: sees only top module ports, core clock domain
// Notes:   idle counts core cycles since chip select was last low
`timescale 1ns/100ps
`default_nettype none
`include "drv_map.svh"
module drv_core_sva
  import drv_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_chip_select_n,
  input  wire logic  i_direct_drive,
  input  wire logic  i_logic_supply_ok,
  input  wire logic  o_serial_data_out,
  input  wire logic  o_serial_data_oe_n,
  input  wire chan_t o_channel_on,
  input  wire logic  o_outputs_oe_n,
  input  wire logic  o_charge_pump_on,
  input  wire logic  o_gate_from_logic_supply,
  input  wire logic  o_standby
);
  logic [3:0] idle;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n)
      idle <= 4'hf;
    else if (!i_chip_select_n)
      idle <= 4'h0;
    else if (idle != 4'hf)
      idle <= idle + 4'h1;
  end
  data_oe_a: assert property (i_chip_select_n |-> o_serial_data_oe_n)
    else $error("data out driven while deselected");
  dout_idle_a: assert property (o_serial_data_oe_n |-> !o_serial_data_out)
    else $error("data out not quiet while released");
  reset_state_a: assert property (!$past(i_rst_n) |-> o_standby && o_outputs_oe_n && !o_charge_pump_on)
    else $error("wrong state after reset");
  supply_float_a: assert property ((!i_logic_supply_ok)[*3] |=> o_outputs_oe_n && o_channel_on == 6'h00)
    else $error("outputs not floated on supply loss");
  pump_gate_a: assert property (o_gate_from_logic_supply != o_charge_pump_on && (!o_charge_pump_on || !o_standby))
    else $error("pump and gate source disagree");
  standby_off_a: assert property (o_standby |-> o_channel_on == 6'h00 && !o_charge_pump_on)
    else $error("output on in standby");
  direct_drive_a: assert property ((i_direct_drive && i_logic_supply_ok && !o_standby)[*5]
    |-> o_channel_on[`DIRECT_CHANNEL])
    else $error("direct input ignored");
  standby_exit_a: assert property ($fell(o_standby) |-> idle < 4'h9)
    else $error("left standby without a frame");
  deselect_hold_a: assert property ((i_chip_select_n && i_logic_supply_ok)[*8]
    |-> $stable(o_standby) && $stable(o_charge_pump_on))
    else $error("state changed while deselected");
  cover property ($fell(o_standby));
  cover property (o_charge_pump_on);
  cover property (o_channel_on == 6'h3f);
endmodule
bind driver_serial_control_core drv_core_sva drv_core_sva_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_chip_select_n(i_chip_select_n),
  .i_direct_drive(i_direct_drive), .i_logic_supply_ok(i_logic_supply_ok),
  .o_serial_data_out(o_serial_data_out), .o_serial_data_oe_n(o_serial_data_oe_n),
  .o_channel_on(o_channel_on), .o_outputs_oe_n(o_outputs_oe_n), .o_charge_pump_on(o_charge_pump_on),
  .o_gate_from_logic_supply(o_gate_from_logic_supply), .o_standby(o_standby));
`default_nettype wire

// ### verification/host_master.sv
// Purpose: host serial master model for the control port
// Assumes: clock idles low, device samples on the rising edge
// Notes:   serial clock runs inside frames and in stray bursts on command, 6 ns period
`timescale 1ns/100ps
`default_nettype none
`include "drv_map.svh"
module host_master
  import drv_pkg::*;
(
  output logic      o_serial_clk,
  output logic      o_chip_select_n,
  output logic      o_serial_data_in,
  input  wire logic i_serial_data_out,
  input  wire logic i_serial_data_oe_n
);
  initial begin
    o_serial_clk = 1'b0;
    o_serial_data_in = 1'b0;
    // one short select pulse at start gives the device bit counter a clean clearing edge
    o_chip_select_n = 1'b0;
    #2;
    o_chip_select_n = 1'b1;
  end
  task automatic xfer(input word_t tx, output word_t rx);
    o_chip_select_n = 1'b0;
    #37;
    for (int i = `WORD_BITS - 1; i >= 0; i--) begin
      o_serial_data_in = tx[i];
      #3;
      rx[i] = i_serial_data_oe_n ? 1'bx : i_serial_data_out;
      o_serial_data_clk_hi();
    end
    #3;
    o_chip_select_n = 1'b1;
    o_serial_data_in = ~o_serial_data_in;
    #37;
  endtask
  task automatic o_serial_data_clk_hi();
    o_serial_clk = 1'b1;
    #3;
    o_serial_clk = 1'b0;
  endtask
  // stray edges while deselected, only on command
  task automatic stray(input word_t tx);
    for (int i = `WORD_BITS - 1; i >= 0; i--) begin
      o_serial_data_in = tx[i];
      #3;
      o_serial_data_clk_hi();
    end
  endtask
endmodule
`default_nettype wire

// ### verification/test_driver_serial_control_core.sv
// Purpose: self-checking bench of the serial control core
// Assumes: host model drives the serial port, bench drives the levels
// Notes:   expected values come from bench functions
`timescale 1ns/100ps
`default_nettype none
`include "drv_map.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_driver_serial_control_core
  import drv_pkg::*;
;
  logic  clk, rst_n, sck, cs_n, sdin, dir, sup_ok, sdo, sdo_oe_n, oe_n, pump, gate, stby;
  chan_t fault, chan, cmd, pwm, f;
  word_t rx;
  int    n_mismatch, cmp_count;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  driver_serial_control_core driver_serial_control_core_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_serial_clk(sck), .i_chip_select_n(cs_n),
    .i_serial_data_in(sdin), .i_direct_drive(dir), .i_logic_supply_ok(sup_ok),
    .i_channel_fault(fault), .o_serial_data_out(sdo), .o_serial_data_oe_n(sdo_oe_n),
    .o_channel_on(chan), .o_outputs_oe_n(oe_n), .o_charge_pump_on(pump),
    .o_gate_from_logic_supply(gate), .o_standby(stby));
  host_master host_master_inst (
    .o_serial_clk(sck), .o_chip_select_n(cs_n), .o_serial_data_in(sdin),
    .i_serial_data_out(sdo), .i_serial_data_oe_n(sdo_oe_n));
  function automatic word_t reply(logic act, logic pm, chan_t st, chan_t ch);
    return {|st, ~act, pm, 1'b0, st, ch};
  endfunction
  function automatic chan_t drive(chan_t c, chan_t p, logic d);
    chan_t r;
    r = c | (p & {`CHANNELS{d}});
    r[`DIRECT_CHANNEL] = r[`DIRECT_CHANNEL] | d;
    return r;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [3:0] ad, input logic [11:0] dat);
    host_master_inst.xfer({ad, dat}, rx);
    step(8);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    // a clean falling edge at 1 ns so the link side asynchronous clear is seen
    rst_n = 1'b1;
    #1;
    rst_n = 1'b0;
    dir = 1'b0;
    sup_ok = 1'b1;
    fault = 6'h00;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(97));
    step(10);
    rst_n = 1'b1;
    step(8);
    `CHK("standby", 1'b1, stby)
    `CHK("float", 1'b0, oe_n)
    `CHK("do_oe", 1'b1, sdo_oe_n)
    `CHK("gate", 1'b1, gate)
    dir = 1'b1;
    send(`ADDR_CTRL0, 12'h000);
    `CHK("reply", reply(1'b0, 1'b0, 6'h00, 6'h00), rx)
    `CHK("chan", 6'h00, chan)
    step(40);
    `CHK("standby", 1'b1, stby)
    send(`ADDR_CTRL0, 12'h001);
    `CHK("standby", 1'b0, stby)
    `CHK("chan", drive(6'h00, 6'h00, 1'b1), chan)
    for (int k = 0; k < 8; k++) begin
      cmd = k < 2 ? 6'h00 : 6'($urandom);
      pwm = k == 0 ? 6'h3f : k == 1 ? 6'h00 : 6'($urandom);
      send(`ADDR_CTRL1, {6'h00, cmd});
      send(`ADDR_CTRL2, {6'h00, pwm});
      dir = k < 2 ? 1'b1 : 1'($urandom);
      step(6);
      `CHK("chan", drive(cmd, pwm, dir), chan)
      send(`ADDR_CLEAR, 12'h000);
      `CHK("reply", reply(1'b1, 1'b0, 6'h00, drive(cmd, pwm, dir)), rx)
    end
    // pump enable and disable bits walked through all four combinations
    for (int k = 0; k < 4; k++) begin
      send(`ADDR_CTRL0, {9'h000, k[1:0], 1'b1});
      `CHK("pump", k == 1, pump)
      `CHK("gate", k != 1, gate)
    end
    dir = 1'b0;
    host_master_inst.stray(16'h0000);
    step(10);
    `CHK("standby", 1'b0, stby)
    `CHK("chan", drive(cmd, pwm, 1'b0), chan)
    send(`ADDR_CTRL1, 12'h03f);
    f = 6'($urandom) | 6'h01;
    fault = f;
    step(6);
    fault = 6'h00;
    send(`ADDR_CLEAR, 12'h000);
    `CHK("reply", reply(1'b1, 1'b0, f, 6'h3f), rx)
    send(`ADDR_CTRL0, 12'h000);
    `CHK("chan", 6'h00, chan)
    send(`ADDR_CLEAR, 12'h000);
    `CHK("reply", reply(1'b0, 1'b0, 6'h00, 6'h00), rx)
    send(`ADDR_CTRL0, 12'h001);
    `CHK("chan", 6'h00, chan)
    send(`ADDR_CTRL1, 12'h03f);
    sup_ok = 1'b0;
    step(5);
    `CHK("float", 1'b1, oe_n)
    `CHK("chan", 6'h00, chan)
    sup_ok = 1'b1;
    step(8);
    `CHK("standby", 1'b1, stby)
    send(`ADDR_CLEAR, 12'h000);
    `CHK("reply", reply(1'b0, 1'b0, 6'h00, 6'h00), rx)
    conclude();
  end
endmodule
`default_nettype wire
